// ### logic/tchi2c_pkg.sv
// Purpose: Shared constants for the touch controller serial host port.
// Assumes: 100 MHz mclk.
// Notes: Register map and timing constants.
package tchi2c_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [5:0] SLAVE_ADDR_HI = 6'b10_0100;
    localparam int CMD_ID_BIT = 7;
    localparam int CMD_ADDR_MSB = 6;
    localparam int CMD_ADDR_LSB = 3;
    localparam int CMD_BIAS_BIT = 1;
    localparam int CMD_DIR_BIT = 0;
    localparam int SOFT_RESET_BIT = 1;
    localparam logic [3:0] PTR_RESET = 4'h0;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [3:0] RW_FIRST = 4'h8;
    localparam logic [3:0] RW_LAST = 4'hE;
    // External reset pin timing
    localparam int RESET_ACCEPT_US = 10;
    localparam int RESET_REJECT_US = 5;
    localparam int SPIKE_NS = 20;
    localparam int RESET_ACCEPT_CYC = (RESET_ACCEPT_US * 1000) / CLK_PERIOD_NS;
    localparam int RESET_REJECT_CYC = (RESET_REJECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_THRESH_CYC = (RESET_ACCEPT_CYC + RESET_REJECT_CYC) / 2;
    localparam int POR_STRETCH_CYC = 64;
    typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_WRX, ST_TXB, ST_MACK, ST_SKIP} tchi2c_state_t;
endpackage : tchi2c_pkg

// ### logic/tchi2c_reset_gen.sv
// Purpose: Combines power-on, filtered pin and soft resets into one reset.
// Assumes: All inputs synchronous to mclk.
// Notes: Pin pulses are measured after spike filtering.
`timescale 1ns/100ps
module tchi2c_reset_gen
    import tchi2c_pkg::*;
(
    // Clock and power-good reset
    input wire logic mclk,
    input wire logic reset_n,
    // Reset sources
    input wire logic extReset_n,
    input wire logic softReset,
    // Results
    output logic hardReset,
    output logic anyReset
);
    logic [7:0] porCount;
    logic [3:0] spikeCount;
    logic pinLow;
    logic [15:0] lowCount;
    logic pinPulse;

    // Stretch the power-good reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            porCount <= 8'h00;
        end else if (porCount != 8'(POR_STRETCH_CYC)) begin
            porCount <= porCount + 8'h01;
        end
    end

    // Spike filter: pin must hold a new level for SPIKE_CYC+1 cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            spikeCount <= 4'h0;
            pinLow <= 1'b0;
        end else if ((!extReset_n) == pinLow) begin
            spikeCount <= 4'h0;
        end else if (spikeCount == 4'(SPIKE_CYC)) begin
            pinLow <= !extReset_n;
            spikeCount <= 4'h0;
        end else begin
            spikeCount <= spikeCount + 4'h1;
        end
    end

    // Accept low pulses beyond the midpoint between 5 us and 10 us
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lowCount <= 16'h0000;
            pinPulse <= 1'b0;
        end else if (pinLow) begin
            if (lowCount != 16'(RESET_THRESH_CYC)) begin
                lowCount <= lowCount + 16'h0001;
            end
            pinPulse <= (lowCount == 16'(RESET_THRESH_CYC));
        end else begin
            lowCount <= 16'h0000;
            pinPulse <= 1'b0;
        end
    end

    // Hard resets win over soft reset
    assign hardReset = (porCount != 8'(POR_STRETCH_CYC)) || pinPulse;
    assign anyReset = hardReset || softReset;
endmodule : tchi2c_reset_gen

// ### logic/tchi2c_host_port.sv
// Purpose: Serial slave host port with register pointer and reset logic.
// Assumes: SCL/SDA sampled synchronously to mclk; mclk much faster than SCL.
// Notes: Register words read through regRdData; writes go out on regWr*.
// How it works
// - Address is 100100 plus select pin
// - Select pin captured once after power-up
// - Address latched on SCL fall after direction
// - Eighth address bit picks read or write
// - Acknowledge matching address for one clock
// - Write cycle: command byte then acknowledge
// - Read: two bytes, master acks first
// - Clock stretching simply pauses the transfer
// - Pointer advances per register, wraps at 16
// - Stop ends high-speed, previous mode returns
// - Power-good creates a stretched internal reset
// - Pin reset accepted at 10us, not 5us
// - Pin glitches up to 20ns filtered
// - Soft reset bit holds until cleared
// - Hard resets outrank and clear soft reset
// - Direction bit sets pointer or writes register
// - Command bit 7 selects conversion byte
// - Bias keep-on level drives bias control
// - Writable registers only at 8 to E
`timescale 1ns/100ps
module tchi2c_host_port
    import tchi2c_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Pins
    input wire logic address_select_pin,
    input wire logic extReset_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Register file side
    input wire logic [15:0] regRdData,
    output logic [3:0] regAddr,
    output logic regWrEn,
    output logic [15:0] regWrData,
    // Controls
    output logic bias_keep_on,
    output logic soft_reset_control,
    output logic [7:0] convCmd,
    output logic convCmdStrobe,
    output logic deviceReset
);
    // Protocol state and pin history
    tchi2c_state_t state;
    logic sclQ;
    logic sdaQ;
    logic addrLsb;
    logic addrCaught;
    logic isRead;
    logic matched;
    logic ackIsAddr;
    // Byte assembly and register pointer
    logic [7:0] shift;
    logic [3:0] bitCount;
    logic [3:0] register_pointer_bits;
    // Read word, byte half and write phase (0 command, 1 high, 2 low, 3 word done)
    logic [15:0] txWord;
    logic hiByte;
    logic [2:0] rxCount;
    // Outputs of the reset combiner
    logic hardReset;
    logic anyReset;

    wire sclRise = sclIn && !sclQ;
    wire sclFall = !sclIn && sclQ;
    wire startCond = sclIn && sclQ && sdaQ && !sdaIn;
    wire stopCond = sclIn && sclQ && !sdaQ && sdaIn;
    wire [7:0] rxByte = {shift[6:0], sdaIn};
    // Match address with latched select bit
    wire addrHit = (shift[7:1] == {SLAVE_ADDR_HI, addrLsb});
    wire cmdIsConv = shift[CMD_ID_BIT];
    wire ptrWritable = (register_pointer_bits >= RW_FIRST) && (register_pointer_bits <= RW_LAST);

    tchi2c_reset_gen u_reset (
        .mclk(mclk),
        .reset_n(reset_n),
        .extReset_n(extReset_n),
        .softReset(soft_reset_control),
        .hardReset(hardReset),
        .anyReset(anyReset)
    );
    assign deviceReset = anyReset;
    assign regAddr = register_pointer_bits;

    // Bit n of the outgoing word, counted from the top of the chosen byte
    function automatic logic tx_bit(input logic [15:0] w, input logic hi, input logic [3:0] n);
        return hi ? w[4'd15 - n] : w[4'd7 - n];
    endfunction : tx_bit


    // Pin sampling and one-time capture of the select pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
            addrLsb <= 1'b0;
            addrCaught <= 1'b0;
        end else begin
            sclQ <= sclIn;
            sdaQ <= sdaIn;
            if (!addrCaught) begin
                addrLsb <= address_select_pin;
                addrCaught <= 1'b1;
            end
        end
    end

    // Soft reset persists until written zero or a hard reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset_control <= 1'b0;
        end else if (hardReset) begin
            soft_reset_control <= 1'b0;
        end else if (state == ST_WRX && sclFall && bitCount == 4'd8 && rxCount == 3'd0
                     && cmdIsConv) begin
            soft_reset_control <= shift[SOFT_RESET_BIT];
        end
    end

    // Protocol engine; no speed-mode state needed since timing follows SCL
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bitCount <= 4'h0;
            isRead <= 1'b0;
            matched <= 1'b0;
            ackIsAddr <= 1'b0;
            sdaOut <= 1'b1;
            sdaOe <= 1'b0;
            register_pointer_bits <= PTR_RESET;
            bias_keep_on <= 1'b0;
            regWrEn <= 1'b0;
            regWrData <= REG_RESET;
            convCmd <= 8'h00;
            convCmdStrobe <= 1'b0;
            txWord <= REG_RESET;
            hiByte <= 1'b1;
            rxCount <= 3'd0;
        end else if (hardReset) begin
            // Soft reset is handled below so the bus can still release it
            state <= ST_IDLE;
            sdaOe <= 1'b0;
            register_pointer_bits <= PTR_RESET;
            bias_keep_on <= 1'b0;
            regWrEn <= 1'b0;
            convCmdStrobe <= 1'b0;
            bitCount <= 4'h0;
            rxCount <= 3'd0;
        end else begin
            regWrEn <= 1'b0;
            convCmdStrobe <= 1'b0;
            if (startCond) begin
                state <= ST_ADDR; // Start or repeated start
                bitCount <= 4'h0;
                rxCount <= 3'd0; // Next write byte is a command
                sdaOe <= 1'b0;
            end else if (stopCond) begin
                state <= ST_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (sclRise) begin
                            shift <= rxByte;
                            bitCount <= bitCount + 4'h1;
                        end
                        // Latch address on fall after the direction bit
                        if (sclFall && bitCount == 4'd8) begin
                            isRead <= shift[0];
                            matched <= addrHit;
                            if (addrHit) begin
                                sdaOut <= 1'b0;
                                sdaOe <= 1'b1;
                                ackIsAddr <= 1'b1;
                                state <= ST_ACK;
                            end else begin
                                state <= ST_SKIP;
                            end
                        end
                    end
                    ST_ACK: begin
                        // Release after one SCL clock
                        if (sclFall) begin
                            bitCount <= 4'h0;
                            // Step to the next register once a written word is acked
                            if (rxCount == 3'd3) begin
                                register_pointer_bits <= register_pointer_bits + 4'h1;
                                rxCount <= 3'd1;
                            end
                            if (ackIsAddr && isRead) begin
                                txWord <= regRdData;
                                hiByte <= 1'b1;
                                sdaOut <= tx_bit(regRdData, 1'b1, 4'h0);
                                sdaOe <= 1'b1;
                                state <= ST_TXB;
                            end else begin
                                sdaOe <= 1'b0;
                                state <= ST_WRX;
                            end
                            ackIsAddr <= 1'b0;
                        end
                    end
                    ST_WRX: begin
                        if (sclRise) begin
                            shift <= rxByte;
                            bitCount <= bitCount + 4'h1;
                        end
                        if (sclFall && bitCount == 4'd8) begin
                            sdaOut <= 1'b0;
                            sdaOe <= 1'b1;
                            state <= ST_ACK;
                            if (rxCount == 3'd0) begin
                                if (cmdIsConv) begin
                                    convCmd <= shift;
                                    convCmdStrobe <= 1'b1;
                                end else begin
                                    // Command byte fields
                                    register_pointer_bits <= shift[CMD_ADDR_MSB:CMD_ADDR_LSB];
                                    bias_keep_on <= shift[CMD_BIAS_BIT];
                                    // Pointer only, or data follows
                                    rxCount <= shift[CMD_DIR_BIT] ? 3'd0 : 3'd1;
                                end
                            end else if (rxCount == 3'd1) begin
                                regWrData[15:8] <= shift;
                                rxCount <= 3'd2;
                            end else begin
                                // Strobe while the pointer still names this register
                                regWrData[7:0] <= shift;
                                regWrEn <= ptrWritable;
                                rxCount <= 3'd3;
                            end
                        end
                    end
                    ST_TXB: begin
                        // Bits shift out on SCL falls; stretching just delays falls
                        if (sclFall) begin
                            bitCount <= bitCount + 4'h1;
                            if (bitCount == 4'd7) begin
                                sdaOe <= 1'b0;
                                state <= ST_MACK;
                                // Advance after the low byte so the next word is ready
                                if (!hiByte) begin
                                    register_pointer_bits <= register_pointer_bits + 4'h1;
                                end
                            end else begin
                                sdaOut <= tx_bit(txWord, hiByte, bitCount + 4'h1);
                            end
                        end
                    end
                    ST_MACK: begin
                        if (sclRise) begin
                            matched <= !sdaIn; // Low means master acknowledges
                        end
                        if (sclFall) begin
                            bitCount <= 4'h0;
                            if (!matched) begin
                                state <= ST_SKIP;
                            end else if (hiByte) begin
                                hiByte <= 1'b0;
                                sdaOut <= tx_bit(txWord, 1'b0, 4'h0);
                                sdaOe <= 1'b1;
                                state <= ST_TXB;
                            end else begin
                                // Pointer already names the next register
                                txWord <= regRdData;
                                hiByte <= 1'b1;
                                sdaOut <= tx_bit(regRdData, 1'b1, 4'h0);
                                sdaOe <= 1'b1;
                                state <= ST_TXB;
                            end
                        end
                    end
                    ST_SKIP: begin
                        sdaOe <= 1'b0;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
            // Soft reset clears the pointer and bias level, winning over a command
            if (soft_reset_control) begin
                register_pointer_bits <= PTR_RESET;
                bias_keep_on <= 1'b0;
            end
        end
    end
endmodule : tchi2c_host_port

// ### tb/tchi2c_asserts.sv
// Purpose: Port checks for the serial host port.
// Assumes: One clock domain, mclk.
// Notes: Bound to the design top below.
`timescale 1ns/100ps
module tchi2c_asserts
    import tchi2c_pkg::*;
(
    // Clock, reset and pins
    input wire logic mclk, reset_n, address_select_pin, extReset_n, sclIn, sdaIn,
    input wire logic sdaOut, sdaOe,
    // Register side and controls
    input wire logic [15:0] regRdData, regWrData,
    input wire logic [3:0] regAddr,
    input wire logic regWrEn, bias_keep_on, soft_reset_control, convCmdStrobe, deviceReset,
    input wire logic [7:0] convCmd
);
    logic [6:0] porCnt;
    logic [11:0] lowCnt;
    logic prevExt;
    logic hitRst;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Tracks stretch age, pin low time and whether a reset showed
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            porCnt <= '0;
            lowCnt <= '0;
            prevExt <= 1'b1;
            hitRst <= 1'b0;
        end else begin
            porCnt <= (porCnt < 7'd100) ? porCnt + 7'd1 : porCnt;
            prevExt <= extReset_n;
            lowCnt <= extReset_n ? lowCnt : (prevExt ? 12'd1 : lowCnt + 12'd1);
            hitRst <= (!extReset_n && prevExt) ? 1'b0 : (hitRst || (deviceReset && !soft_reset_control));
        end
    end
    sda_on_fall_a: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("Data enable moved while clock high");
    wr_pulse_a: assert property (regWrEn |=> !regWrEn)
        else $error("Write strobe longer than one cycle");
    wr_range_a: assert property (regWrEn |-> regAddr inside {[RW_FIRST:RW_LAST]})
        else $error("Write to a read-only register");
    conv_id_a: assert property (convCmdStrobe |-> convCmd[CMD_ID_BIT] ##1 !convCmdStrobe)
        else $error("Bad conversion command strobe");
    soft_hold_a: assert property (soft_reset_control |-> deviceReset ##1 !bias_keep_on)
        else $error("Soft reset not holding the device");
    por_long_a: assert property (porCnt < POR_STRETCH_CYC |-> deviceReset)
        else $error("Power-on reset too short");
    por_end_a: assert property (porCnt == POR_STRETCH_CYC |-> !deviceReset)
        else $error("Power-on reset too long");
    pin_take_a: assert property ($rose(extReset_n) && lowCnt >= RESET_ACCEPT_CYC
        |-> ##8 hitRst && !soft_reset_control) else $error("Long pin pulse not taken");
    pin_drop_a: assert property ($rose(deviceReset) && !soft_reset_control && porCnt > 7'd70
        |-> lowCnt > RESET_REJECT_CYC) else $error("Short pin pulse caused reset");
endmodule : tchi2c_asserts

bind tchi2c_host_port tchi2c_asserts u_tchi2c_asserts (.mclk(mclk), .reset_n(reset_n),
    .address_select_pin(address_select_pin), .extReset_n(extReset_n), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .regRdData(regRdData),
    .regWrData(regWrData), .regAddr(regAddr), .regWrEn(regWrEn),
    .bias_keep_on(bias_keep_on), .soft_reset_control(soft_reset_control),
    .convCmdStrobe(convCmdStrobe), .deviceReset(deviceReset), .convCmd(convCmd));

// ### tb/tchi2c_mst.sv
// Purpose: Bus master model driving clock and data lines.
// Assumes: Bench resolves the open-drain data line with a pull-up.
// Notes: Each byte result is pulsed on obsValid for the bench.
`timescale 1ns/100ps
module tchi2c_mst (
    // Clock and bus
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sdaLow,
    // Byte results
    output logic obsValid,
    output logic [8:0] obsVal
);
    localparam int HALF = 8;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
        obsValid = 1'b0;
        obsVal = 9'h000;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    // Data moves only while clock low, sampled just before the fall
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sdaLow = !b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        r = sda;
        scl = 1'b0;
    endtask : bit_io
    // Start or repeated start: data falls while clock high
    task automatic start_bit();
        sdaLow = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sdaLow = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask : start_bit
    // Stop ends every transfer, also after an early not-acknowledge
    task automatic stop_bit();
        sdaLow = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sdaLow = 1'b0;
        tick(HALF);
    endtask : stop_bit
    // Byte plus ninth bit; stretch holds the clock low first
    task automatic xfer(input logic [7:0] tx, input logic rd, input logic ackIn, input int stretch);
        logic [7:0] rx;
        logic ack;
        tick(stretch);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ackIn, ack);
        obsVal = rd ? {rx, ackIn} : {8'h00, ack};
        obsValid = 1'b1;
        tick(1);
        obsValid = 1'b0;
    endtask : xfer
endmodule : tchi2c_mst

// ### tb/touch_ctrl_i2c_host_port_test.sv
// Purpose: Self-checking bench for the serial host port.
// Assumes: Master model owns the bus lines.
// Notes: Results are queued per kind and matched by monitors.
`timescale 1ns/100ps
module touch_ctrl_i2c_host_port_test
    import tchi2c_pkg::*;
;
    logic mclk, reset_n, address_select_pin, extReset_n, sclIn, sdaLow, sdaOut, sdaOe;
    logic regWrEn, bias_keep_on, soft_reset_control, convCmdStrobe, deviceReset;
    logic obsValid, probeReq;
    logic [8:0] obsVal;
    logic [3:0] regAddr;
    logic [7:0] convCmd;
    logic [15:0] regWrData;
    logic [15:0] regs[16];
    logic [31:0] expQ[5][$];
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    wire sdaLine = !(sdaLow || (sdaOe && !sdaOut));
    wire [15:0] regRdData = regs[regAddr];
    tchi2c_host_port u_tchi2c_host_port (.mclk(mclk), .reset_n(reset_n),
        .address_select_pin(address_select_pin), .extReset_n(extReset_n), .sclIn(sclIn),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .regRdData(regRdData),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .bias_keep_on(bias_keep_on), .soft_reset_control(soft_reset_control),
        .convCmd(convCmd), .convCmdStrobe(convCmdStrobe), .deviceReset(deviceReset));
    tchi2c_mst u_tchi2c_mst (.mclk(mclk), .sda(sdaLine), .scl(sclIn), .sdaLow(sdaLow),
        .obsValid(obsValid), .obsVal(obsVal));
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    task automatic wrap_up();
        for (int k = 0; k < 5; k++) if (expQ[k].size() != 0) miscompares++;
        $display("Checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    // Matches a seen result against the oldest note of its kind
    task automatic take(input logic [31:0] got);
        logic [31:0] want;
        want = 'x;
        if (expQ[got[31:28]].size() != 0) want = expQ[got[31:28]].pop_front();
        checks++;
        if (got !== want) begin
            $display("Error at %0t ns: got %h, expected %h", $time, got, want);
            miscompares++;
        end
    endtask : take
    // Pulses are taken where settled, bench strobes at the rising edge
    always @(negedge mclk) begin
        if (regWrEn) take({4'h2, 8'h00, regAddr, regWrData});
        if (convCmdStrobe) take({4'h3, 20'h0_0000, convCmd});
    end
    always @(posedge mclk) begin
        if (obsValid) take({4'h1, 19'h0_0000, obsVal});
        if (probeReq) begin
            take({4'h4, 25'h000_0000, bias_keep_on, soft_reset_control, deviceReset});
        end
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic send(input logic [7:0] b, input logic ack);
        expQ[1].push_back({4'h1, 19'h0_0000, 8'h00, ack});
        u_tchi2c_mst.xfer(b, 1'b0, 1'b1, 0);
    endtask : send
    task automatic head(input logic rd, input logic lsb, input logic ack);
        u_tchi2c_mst.start_bit();
        send({SLAVE_ADDR_HI, lsb, rd}, ack);
    endtask : head
    task automatic probe(input logic [2:0] e);
        expQ[4].push_back({4'h4, 25'h000_0000, e});
        probeReq = 1'b1;
        @(negedge mclk);
        probeReq = 1'b0;
    endtask : probe
    task automatic wr_reg(input logic [3:0] a, input logic b, input logic [15:0] d);
        head(1'b0, 1'b1, 1'b0);
        send({1'b0, a, 1'b0, b, 1'b0}, 1'b0);
        if (a inside {[RW_FIRST:RW_LAST]}) expQ[2].push_back({4'h2, 8'h00, a, d});
        if (a inside {[RW_FIRST:RW_LAST]}) regs[a] = d;
        send(d[15:8], 1'b0);
        send(d[7:0], 1'b0);
        u_tchi2c_mst.stop_bit();
    endtask : wr_reg
    task automatic rd_seq(input logic [3:0] a, input int n, input int stretch);
        logic [15:0] w;
        head(1'b0, 1'b1, 1'b0);
        send({1'b0, a, 3'b001}, 1'b0);
        u_tchi2c_mst.stop_bit();
        head(1'b1, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            w = regs[4'(a + i / 2)];
            expQ[1].push_back({4'h1, 19'h0_0000, i % 2 ? w[7:0] : w[15:8], 1'(i == n - 1)});
            u_tchi2c_mst.xfer(8'hFF, 1'b1, 1'(i == n - 1), i % 2 ? stretch : 0);
        end
        u_tchi2c_mst.stop_bit();
    endtask : rd_seq
    task automatic conv(input logic [7:0] c);
        head(1'b0, 1'b1, 1'b0);
        expQ[3].push_back({4'h3, 20'h0_0000, c});
        send(c, 1'b0);
        u_tchi2c_mst.stop_bit();
    endtask : conv
    task automatic pin(input int n);
        extReset_n = 1'b0;
        repeat (n) @(negedge mclk);
        extReset_n = 1'b1;
        repeat (100) @(negedge mclk);
    endtask : pin
    // Main sequence
    initial begin
        void'($urandom(32'hc208ebfe));
        mclk = 1'b0;
        reset_n = 1'b0;
        address_select_pin = 1'b1;
        extReset_n = 1'b1;
        probeReq = 1'b0;
        foreach (regs[i]) regs[i] = 16'($urandom());
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        repeat (2) @(negedge mclk);
        address_select_pin = 1'b0;
        repeat (80) @(negedge mclk);
        probe(3'b000);
        head(1'b0, 1'b0, 1'b1);
        u_tchi2c_mst.stop_bit();
        $display("Test address done");
        for (int a = 8; a < 15; a++) wr_reg(4'(a), 1'b0, 16'($urandom()));
        wr_reg(4'h3, 1'b0, 16'($urandom()));
        wr_reg(4'hF, 1'b1, 16'($urandom()));
        probe(3'b100);
        $display("Test write done");
        rd_seq(4'hE, 6, 40);
        rd_seq(4'h9, 1, 0);
        rd_seq(4'h8, 2, 0);
        $display("Test read done");
        wr_reg(4'h8, 1'b0, 16'($urandom()));
        conv(8'h82);
        probe(3'b011);
        conv(8'h80);
        probe(3'b000);
        $display("Test soft reset done");
        conv(8'h82);
        pin(SPIKE_CYC);
        probe(3'b011);
        pin(RESET_REJECT_CYC - 100);
        probe(3'b011);
        pin(RESET_ACCEPT_CYC + 100);
        probe(3'b000);
        pin(RESET_ACCEPT_CYC + 100);
        probe(3'b000);
        $display("Test pin reset done");
        repeat (50) @(negedge mclk);
        wrap_up();
    end
endmodule : touch_ctrl_i2c_host_port_test
